// File: core/cas_core.sv
// Purpose: cpu arithmetic and program-control datapath behind apb
// Assumes: single 10 MHz clock, software loads one instruction at a time
// Notes: machine cycle is two clocks, flash fetch adds one machine cycle
// Summary of operation
// - unimplemented bits always read as zero
// - writes to unimplemented bits change nothing
// - write-only bits read back as zero
// - read-only bits ignore software writes
// - hardware may also update status bits
// - machine cycle lasts two clock periods
// - rom or ram access needs no wait
// - flash access adds one wait machine cycle
// - decoder handles one, two, three byte instructions
// - decoder selects transfer sources and alu operation
// - alu with operand registers and flag word
// - alu yields 8-bit result from operands
// - add, sub, mul, div, inc, dec, bcd, compare
// - logic, complement, rotates and nibble swap
// - bit set, clear, complement, jumps, carry moves
// - carry and-or with bit or inverse
// - 16-bit pointer holds next instruction address
// - internal and external events redirect execution; here only the synchronised external event does, through the event jump
// - parity flag tracks one bits of accumulator
// - bank bits give bank base times eight
// - secondary register feeds multiply and divide
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cas_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire cas_pkg::cas_apb_req_t apb_req,
  output var cas_pkg::cas_apb_rsp_t apb_rsp,
  // events and status
  input wire logic ext_event,
  output logic [7:0] bank_base,
  output logic busy
);
  import cas_pkg::*;

  typedef struct packed {
    cas_state_t state;
    logic phase;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] processor_flag_word;
    logic [7:0] scratch;
    logic [15:0] pc;
    logic [INSTR_W-1:0] instr;
    logic flash;
    logic pready;
    logic perr;
    logic [31:0] prdata;
    logic ev_s1;
    logic ev_s2;
    logic [7:0] run;
    logic [7:0] mcyc;
    logic [7:0] bank;
    logic busy;
  } cas_regs_t;

  cas_regs_t st;
  cas_regs_t next_st;

  always_comb begin
    cas_op_t op;
    logic [7:0] a;
    logic [7:0] imm;
    logic [7:0] rel;
    logic [8:0] s9;
    logic [8:0] t9;
    logic [4:0] h5;
    logic [15:0] p16;
    logic [2:0] bidx;
    logic [1:0] bsel;
    logic bitv;
    logic nb;
    logic bw;
    logic take;
    logic cy;
    logic cin;
    logic last;
    logic setup;
    logic wr;
    logic [31:0] rd;
    logic rerr;
    op = cas_op_t'(st.instr[OP_LSB +: OP_W]);
    a = st.acc;
    imm = st.instr[IMM_LSB +: 8];
    rel = st.instr[REL_LSB +: 8];
    cy = st.processor_flag_word[PSW_CY];
    bidx = imm[BIDX_LSB +: 3];
    bsel = imm[BSEL_LSB +: 2];
    s9 = '0;
    t9 = '0;
    h5 = '0;
    p16 = '0;
    nb = 1'b0;
    bw = 1'b0;
    take = 1'b0;
    cin = 1'b0;
    last = (st.phase == MC_LAST);
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && st.pready && apb_req.pwrite;
    rd = '0;
    rerr = 1'b0;
    next_st = st;
    // any addressable bit: scratch byte, accumulator or carry
    bitv = (bsel == BSEL_SCR) ? st.scratch[bidx] : ((bsel == BSEL_ACC) ? a[bidx] : cy);
    // two-flop synchroniser for the event pin
    next_st.ev_s1 = ext_event;
    next_st.ev_s2 = st.ev_s1;
    next_st.processor_flag_word[PSW_P] = ^st.acc;
    next_st.bank = '0;
    next_st.bank[BANK_LSB +: 2] = st.processor_flag_word[PSW_RS1:PSW_RS0];
    // read data is captured in the setup cycle
    if (apb_req.paddr == CAS_A_CTRL) begin
      rd[CTRL_FLASH] = st.flash;
    end else if (apb_req.paddr == CAS_A_INSTR) begin
      rd[INSTR_W-1:0] = st.instr;
    end else if (apb_req.paddr == CAS_A_ACC) begin
      rd[7:0] = st.acc;
    end else if (apb_req.paddr == CAS_A_BREG) begin
      rd[7:0] = st.b;
    end else if (apb_req.paddr == CAS_A_PSW) begin
      rd[7:0] = st.processor_flag_word;
    end else if (apb_req.paddr == CAS_A_PC) begin
      rd[15:0] = st.pc;
    end else if (apb_req.paddr == CAS_A_STAT) begin
      rd[STAT_MC_LSB +: 8] = st.mcyc;
      rd[0] = st.busy;
    end else if (apb_req.paddr == CAS_A_BITS) begin
      rd[7:0] = st.scratch;
    end else begin
      rerr = 1'b1;
    end
    next_st.pready = setup;
    if (setup) begin
      next_st.prdata = rd;
      next_st.perr = rerr;
    end
    // software writes land only while idle
    if (wr && st.state == CAS_IDLE) begin
      if (apb_req.paddr == CAS_A_CTRL) begin
        next_st.flash = apb_req.pwdata[CTRL_FLASH];
        if (apb_req.pwdata[CTRL_GO]) begin
          next_st.state = CAS_FETCH;
          next_st.phase = 1'b0;
          next_st.run = '0;
        end
      end else if (apb_req.paddr == CAS_A_INSTR) begin
        next_st.instr = apb_req.pwdata[INSTR_W-1:0];
      end else if (apb_req.paddr == CAS_A_ACC) begin
        next_st.acc = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == CAS_A_BREG) begin
        next_st.b = apb_req.pwdata[7:0];
      end else if (apb_req.paddr == CAS_A_PSW) begin
        next_st.processor_flag_word[PSW_CY:PSW_F1] = apb_req.pwdata[PSW_CY:PSW_F1];
      end else if (apb_req.paddr == CAS_A_PC) begin
        next_st.pc = apb_req.pwdata[15:0];
      end else if (apb_req.paddr == CAS_A_BITS) begin
        next_st.scratch = apb_req.pwdata[7:0];
      end
    end
    if (st.state != CAS_IDLE) begin
      next_st.phase = ~st.phase;
      if (last) begin
        next_st.run = st.run + 8'h01;
      end
    end
    case (st.state)
      CAS_FETCH: begin
        if (last) begin
          next_st.pc = st.pc + {14'h0, cas_len(op)};
          next_st.state = st.flash ? CAS_WAIT : CAS_EXEC;
        end
      end
      CAS_WAIT: begin
        if (last) begin
          next_st.state = CAS_EXEC;
        end
      end
      CAS_EXEC: begin
        if (last) begin
          next_st.state = CAS_IDLE;
          next_st.mcyc = st.run + 8'h01;
          case (op)
            OP_ADD, OP_ADDC: begin
              cin = (op == OP_ADDC) && cy;
              s9 = {1'b0, a} + {1'b0, imm} + {8'h00, cin};
              h5 = {1'b0, a[3:0]} + {1'b0, imm[3:0]} + {4'h0, cin};
              next_st.acc = s9[7:0];
              next_st.processor_flag_word[PSW_CY] = s9[8];
              next_st.processor_flag_word[PSW_AC] = h5[4];
              next_st.processor_flag_word[PSW_OV] = (a[7] == imm[7]) && (s9[7] != a[7]);
            end
            OP_SUBB, OP_CMPJ: begin
              cin = (op == OP_SUBB) && cy;
              s9 = {1'b0, a} - {1'b0, imm} - {8'h00, cin};
              h5 = {1'b0, a[3:0]} - {1'b0, imm[3:0]} - {4'h0, cin};
              next_st.processor_flag_word[PSW_CY] = s9[8];
              if (op == OP_SUBB) begin
                next_st.acc = s9[7:0];
                next_st.processor_flag_word[PSW_AC] = h5[4];
                next_st.processor_flag_word[PSW_OV] = (a[7] != imm[7]) && (s9[7] != a[7]);
              end else begin
                take = (a != imm);
              end
            end
            OP_INC: next_st.acc = a + 8'h01;
            OP_DEC: next_st.acc = a - 8'h01;
            OP_MUL: begin
              p16 = {8'h00, a} * {8'h00, st.b};
              next_st.acc = p16[7:0];
              next_st.b = p16[15:8];
              next_st.processor_flag_word[PSW_CY] = 1'b0;
              next_st.processor_flag_word[PSW_OV] = |p16[15:8];
            end
            OP_DIV: begin
              next_st.processor_flag_word[PSW_CY] = 1'b0;
              next_st.processor_flag_word[PSW_OV] = (st.b == 8'h00);
              if (st.b != 8'h00) begin
                next_st.acc = a / st.b;
                next_st.b = a % st.b;
              end
            end
            OP_DA: begin
              t9 = {1'b0, a};
              if (a[3:0] > BCD_MAX || st.processor_flag_word[PSW_AC]) begin
                t9 = t9 + DA_LO;
              end
              if (t9[7:4] > BCD_MAX || t9[8] || cy) begin
                t9 = t9 + DA_HI;
              end
              next_st.acc = t9[7:0];
              next_st.processor_flag_word[PSW_CY] = cy || t9[8];
            end
            OP_AND: next_st.acc = a & imm;
            OP_OR: next_st.acc = a | imm;
            OP_XOR: next_st.acc = a ^ imm;
            OP_CPL: next_st.acc = ~a;
            OP_RR: next_st.acc = {a[0], a[7:1]};
            OP_RL: next_st.acc = {a[6:0], a[7]};
            OP_SWAP: next_st.acc = {a[3:0], a[7:4]};
            OP_SETB: begin
              nb = 1'b1;
              bw = 1'b1;
            end
            OP_CLRB: bw = 1'b1;
            OP_CPLB: begin
              nb = ~bitv;
              bw = 1'b1;
            end
            OP_C2B: begin
              nb = cy;
              bw = 1'b1;
            end
            OP_B2C: next_st.processor_flag_word[PSW_CY] = bitv;
            OP_ANLC: next_st.processor_flag_word[PSW_CY] = cy & bitv;
            OP_ANLNC: next_st.processor_flag_word[PSW_CY] = cy & ~bitv;
            OP_ORLC: next_st.processor_flag_word[PSW_CY] = cy | bitv;
            OP_ORLNC: next_st.processor_flag_word[PSW_CY] = cy | ~bitv;
            OP_JB: take = bitv;
            OP_JNB: take = ~bitv;
            OP_JBC: begin
              take = bitv;
              bw = bitv;
            end
            OP_SJMP: begin
              take = 1'b1;
              rel = imm;
            end
            OP_JEV: begin
              take = st.ev_s2;
              rel = imm;
            end
            default: ;
          endcase
          if (bw) begin
            if (bsel == BSEL_SCR) begin
              next_st.scratch[bidx] = nb;
            end else if (bsel == BSEL_ACC) begin
              next_st.acc[bidx] = nb;
            end else begin
              next_st.processor_flag_word[PSW_CY] = nb;
            end
          end
          if (take) begin
            next_st.pc = st.pc + {{8{rel[7]}}, rel};
          end
        end
      end
      default: ;
    endcase
    next_st.busy = (next_st.state != CAS_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= CAS_IDLE;
      st.processor_flag_word <= PSW_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = {st.pready, st.perr, st.prdata};
  assign bank_base = st.bank;
  assign busy = st.busy;

  // checking helpers
  logic exec_end;
  logic rd_ctrl;
  logic chk_cout;
  logic chk_bit;
  logic [8:0] chk_sum;
  cas_op_t chk_op;
  assign chk_op = cas_op_t'(st.instr[OP_LSB +: OP_W]);
  assign exec_end = (st.state == CAS_EXEC) && (st.phase == MC_LAST);
  assign rd_ctrl = apb_req.psel && apb_req.penable && st.pready && !apb_req.pwrite && apb_req.paddr == CAS_A_CTRL;
  assign chk_sum = {1'b0, st.acc} + {1'b0, st.instr[IMM_LSB +: 8]};
  assign chk_cout = chk_sum[8];
  assign chk_bit = st.scratch[st.instr[IMM_LSB + BIDX_LSB +: 3]];
  property p_unimpl_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_ctrl |-> apb_rsp.prdata[31:CTRL_W] == '0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");
  property p_wo_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    rd_ctrl |-> !apb_rsp.prdata[CTRL_GO];
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("start bit read back nonzero");
  logic wr_stat_idle;
  assign wr_stat_idle = apb_req.psel && apb_req.penable && st.pready && apb_req.pwrite
    && apb_req.paddr == CAS_A_STAT && st.state == CAS_IDLE;
  property p_ro_stat;
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_stat_idle) |=> $stable(st.mcyc) && st.state == CAS_IDLE;
  endproperty
  a_ro_stat: assert property (p_ro_stat) else $error("status altered by write");
  property p_mcycle;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(st.state == CAS_FETCH) |-> (st.state == CAS_FETCH) [*2] ##1 st.state != CAS_FETCH;
  endproperty
  a_mcycle: assert property (p_mcycle) else $error("machine cycle not two clocks");
  property p_nowait;
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(st.state == CAS_FETCH) && !st.flash) |-> ##2 st.state == CAS_EXEC ##2 st.state == CAS_IDLE;
  endproperty
  a_nowait: assert property (p_nowait) else $error("wait state on rom or ram");
  property p_flash;
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(st.state == CAS_FETCH) && st.flash) |-> ##2 st.state == CAS_WAIT ##2 st.state == CAS_EXEC;
  endproperty
  a_flash: assert property (p_flash) else $error("flash wait state missing");
  property p_pc_step;
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(st.state == CAS_FETCH) && !st.flash && chk_op == OP_INC)
      |-> ##4 st.pc == $past(st.pc, 4) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pointer not advanced by length");
  property p_inc;
    @(posedge ref_clk) disable iff (!rst_n)
    (exec_end && chk_op == OP_INC) |=> st.acc == $past(st.acc) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment result wrong");
  property p_add_carry;
    @(posedge ref_clk) disable iff (!rst_n)
    (exec_end && chk_op == OP_ADD) |=> st.processor_flag_word[PSW_CY] == $past(chk_cout);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
  property p_anlc;
    @(posedge ref_clk) disable iff (!rst_n)
    (exec_end && chk_op == OP_ANLC && st.instr[IMM_LSB + BSEL_LSB +: 2] == BSEL_SCR)
      |=> st.processor_flag_word[PSW_CY] == ($past(st.processor_flag_word[PSW_CY]) && $past(chk_bit));
  endproperty
  a_anlc: assert property (p_anlc) else $error("carry and bit wrong");
  // parity follows the accumulator one clock later
  property p_parity;
    @(posedge ref_clk) disable iff (!rst_n)
    (st.state == CAS_IDLE && $past(st.state == CAS_IDLE)) |-> st.processor_flag_word[PSW_P] == ^$past(st.acc);
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");
  property p_bank;
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(st.processor_flag_word[PSW_RS1:PSW_RS0]) |=> bank_base[BANK_LSB +: 2] == $past(st.processor_flag_word[PSW_RS1:PSW_RS0]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  c_flash: cover property (@(posedge ref_clk) disable iff (!rst_n) st.state == CAS_WAIT);
  c_mul: cover property (@(posedge ref_clk) disable iff (!rst_n) exec_end && chk_op == OP_MUL);
  c_jev: cover property (@(posedge ref_clk) disable iff (!rst_n) exec_end && chk_op == OP_JEV && st.ev_s2);
endmodule : cas_core
`default_nettype wire

// File: core/cas_pkg.sv
// Purpose: constants and types of the cpu arithmetic section
// Assumes: apb slave with 8-bit byte address and 32-bit data
// Notes: opcodes and register offsets are local to this block
`default_nettype none
package cas_pkg;
  // machine cycle length in clocks
  localparam int MC_CLKS = 2;
  localparam logic MC_LAST = 1'(MC_CLKS - 1);
  // register byte addresses
  localparam logic [7:0] CAS_A_CTRL = 8'h00;
  localparam logic [7:0] CAS_A_INSTR = 8'h04;
  localparam logic [7:0] CAS_A_ACC = 8'h08;
  localparam logic [7:0] CAS_A_BREG = 8'h0c;
  localparam logic [7:0] CAS_A_PSW = 8'h10;
  localparam logic [7:0] CAS_A_PC = 8'h14;
  localparam logic [7:0] CAS_A_STAT = 8'h18;
  localparam logic [7:0] CAS_A_BITS = 8'h1c;
  // control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_FLASH = 1;
  localparam int CTRL_W = 2;
  // flag word fields
  localparam int PSW_P = 0;
  localparam int PSW_F1 = 1;
  localparam int PSW_OV = 2;
  localparam int PSW_RS0 = 3;
  localparam int PSW_RS1 = 4;
  localparam int PSW_F0 = 5;
  localparam int PSW_AC = 6;
  localparam int PSW_CY = 7;
  localparam logic [7:0] PSW_RESET = 8'h00;
  // instruction word fields
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int IMM_LSB = 8;
  localparam int REL_LSB = 16;
  localparam int INSTR_W = 24;
  localparam int BIDX_LSB = 0;
  localparam int BSEL_LSB = 3;
  localparam int BANK_LSB = 3;
  localparam int STAT_MC_LSB = 8;
  localparam logic [1:0] BSEL_SCR = 2'h0;
  localparam logic [1:0] BSEL_ACC = 2'h1;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] DA_LO = 9'h006;
  localparam logic [8:0] DA_HI = 9'h060;
  typedef enum logic [3:0] {
    CAS_IDLE = 4'b0001,
    CAS_FETCH = 4'b0010,
    CAS_WAIT = 4'b0100,
    CAS_EXEC = 4'b1000
  } cas_state_t;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADDC = 5'h02, OP_SUBB = 5'h03,
    OP_INC = 5'h04, OP_DEC = 5'h05, OP_MUL = 5'h06, OP_DIV = 5'h07,
    OP_DA = 5'h08, OP_CMPJ = 5'h09, OP_AND = 5'h0a, OP_OR = 5'h0b,
    OP_XOR = 5'h0c, OP_CPL = 5'h0d, OP_RR = 5'h0e, OP_RL = 5'h0f,
    OP_SWAP = 5'h10, OP_SETB = 5'h11, OP_CLRB = 5'h12, OP_CPLB = 5'h13,
    OP_JB = 5'h14, OP_JNB = 5'h15, OP_JBC = 5'h16, OP_C2B = 5'h17,
    OP_B2C = 5'h18, OP_ANLC = 5'h19, OP_ANLNC = 5'h1a, OP_ORLC = 5'h1b,
    OP_ORLNC = 5'h1c, OP_SJMP = 5'h1d, OP_JEV = 5'h1e
  } cas_op_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cas_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cas_apb_rsp_t;
  // instruction length in bytes
  function automatic logic [1:0] cas_len(input cas_op_t op);
    case (op)
      OP_CMPJ, OP_JB, OP_JNB, OP_JBC: cas_len = 2'd3;
      OP_NOP, OP_INC, OP_DEC, OP_MUL, OP_DIV, OP_DA, OP_CPL, OP_RR,
      OP_RL, OP_SWAP: cas_len = 2'd1;
      OP_ADD, OP_ADDC, OP_SUBB, OP_AND, OP_OR, OP_XOR, OP_SETB, OP_CLRB,
      OP_CPLB, OP_C2B, OP_B2C, OP_ANLC, OP_ANLNC, OP_ORLC, OP_ORLNC,
      OP_SJMP, OP_JEV: cas_len = 2'd2;
      default: cas_len = 2'd1;
    endcase
  endfunction : cas_len
endpackage : cas_pkg
`default_nettype wire

// File: tb/cas_event_src.sv
// Purpose: external event source beside the cpu arithmetic section
// Assumes: the bench asks for an event level on raise
// Notes: the event pin changes on ref_clk edges, and the core still passes it through its two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module cas_event_src (
  // clock
  input wire logic ref_clk,
  // request from the bench
  input wire logic raise,
  // event pin
  output logic ext_event
);
  initial ext_event = 1'b0;
  always @(posedge ref_clk) begin
    ext_event <= raise;
  end
endmodule : cas_event_src
`default_nettype wire

// File: tb/tb_cpu_arith_section.sv
// Purpose: self-checking bench of the cpu arithmetic section
// Assumes: apb slave answers without a fixed wait count
// Notes: each case loads operands, runs one instruction and reads results back
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_cpu_arith_section;
  import cas_pkg::*;
  logic ref_clk;
  logic rst_n;
  cas_apb_req_t req;
  cas_apb_rsp_t rsp;
  logic ev;
  logic ev_raise;
  logic [7:0] bank_base;
  logic busy;
  logic flash;
  logic [31:0] rd;
  logic er;
  int bad_count;
  int cmp_count;
  cas_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .ext_event(ev),
    .bank_base(bank_base), .busy(busy));
  cas_event_src u_ev (.ref_clk(ref_clk), .raise(ev_raise), .ext_event(ev));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready is seen high or 50 clocks pass
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (rsp.pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, rsp.pready, 1'b1);
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk
  task automatic run(input logic [4:0] op, input logic [7:0] a, b, p, s, o1, o2,
      input logic [7:0] ea, eb, ep, es, input logic [15:0] epc);
    int n;
    apb(1'b1, CAS_A_ACC, {24'h0, a});
    apb(1'b1, CAS_A_BREG, {24'h0, b});
    apb(1'b1, CAS_A_BITS, {24'h0, s});
    apb(1'b1, CAS_A_PSW, {24'h0, p});
    apb(1'b1, CAS_A_PC, 32'h100);
    apb(1'b1, CAS_A_INSTR, {8'h0, o2, o1, 3'h0, op});
    apb(1'b1, CAS_A_CTRL, {30'h0, flash, 1'b1});
    n = 0;
    #1;
    while (busy === 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    `CHK(n, flash ? 6 : 4)
    rchk(CAS_A_STAT, {16'h0, flash ? 8'h3 : 8'h2, 8'h0});
    rchk(CAS_A_ACC, {24'h0, ea});
    rchk(CAS_A_BREG, {24'h0, eb});
    rchk(CAS_A_PSW, {24'h0, ep[7:1], ^ea});
    rchk(CAS_A_BITS, {24'h0, es});
    rchk(CAS_A_PC, {16'h0, epc});
  endtask : run
  initial begin
    req = '0;
    rst_n = 1'b0;
    ev_raise = 1'b0;
    flash = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rchk(8'(i * 4), 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    // start a flash no-op with every ctrl bit set, then write acc while busy
    apb(1'b1, CAS_A_CTRL, 32'hffffffff);
    apb(1'b1, CAS_A_ACC, 32'h55);
    rchk(CAS_A_CTRL, 32'h2);
    rchk(CAS_A_ACC, 32'h0);
    apb(1'b1, CAS_A_STAT, 32'hffffffff);
    rchk(CAS_A_STAT, 32'h300);
    apb(1'b1, CAS_A_PSW, 32'hff);
    rchk(CAS_A_PSW, 32'hfe);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CAS_A_PSW, 32'(i * 8));
      repeat (2) @(posedge ref_clk);
      `CHK(bank_base, 8'(i * 8))
    end
    flash = 1'b0;
    // operands with legal encodings, plus the unused opcode 5'h1f run as a no-op
    run(OP_NOP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_ADD, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h44, 8'h00, 16'h0102);
    run(OP_ADDC, 8'h0f, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h11, 8'h00, 8'h40, 8'h00, 16'h0102);
    run(OP_SUBB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'hc0, 8'h00, 16'h0102);
    run(OP_INC, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_DEC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_MUL, 8'h10, 8'h20, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 16'h0101);
    run(OP_DA, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_CMPJ, 8'h05, 8'h00, 8'h00, 8'h00, 8'h06, 8'hfe, 8'h05, 8'h00, 8'h80, 8'h00, 16'h0101);
    run(OP_CMPJ, 8'h06, 8'h00, 8'h00, 8'h00, 8'h06, 8'hfe, 8'h06, 8'h00, 8'h00, 8'h00, 16'h0103);
    run(OP_AND, 8'h96, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'h14, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(OP_OR, 8'h96, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'hbe, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(OP_XOR, 8'h96, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00, 8'haa, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(OP_CPL, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h69, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_RR, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h4b, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_RL, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2d, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_SWAP, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h69, 8'h00, 8'h00, 8'h00, 16'h0101);
    run(OP_SETB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 16'h0102);
    run(OP_CLRB, 8'h96, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h16, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(OP_CPLB, 8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h54, 16'h0102);
    run(OP_SETB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 16'h0102);
    run(OP_C2B, 8'h00, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'h02, 16'h0102);
    run(OP_B2C, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h80, 8'h04, 16'h0102);
    run(OP_ANLC, 8'h96, 8'h00, 8'h80, 8'h00, 8'h08, 8'h00, 8'h96, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(OP_ANLC, 8'h96, 8'h00, 8'h80, 8'hfe, 8'h00, 8'h00, 8'h96, 8'h00, 8'h00, 8'hfe, 16'h0102);
    run(OP_ANLNC, 8'h96, 8'h00, 8'h80, 8'h00, 8'h08, 8'h00, 8'h96, 8'h00, 8'h80, 8'h00, 16'h0102);
    run(OP_ORLC, 8'h00, 8'h00, 8'h00, 8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h80, 8'h10, 16'h0102);
    run(OP_ORLNC, 8'h00, 8'h00, 8'h00, 8'h10, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 16'h0102);
    run(OP_JB, 8'h00, 8'h00, 8'h00, 8'h08, 8'h03, 8'h10, 8'h00, 8'h00, 8'h00, 8'h08, 16'h0113);
    run(OP_JNB, 8'h00, 8'h00, 8'h00, 8'h08, 8'h03, 8'h10, 8'h00, 8'h00, 8'h00, 8'h08, 16'h0103);
    run(OP_JBC, 8'h00, 8'h00, 8'h00, 8'h08, 8'h03, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0113);
    run(OP_SJMP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0082);
    run(OP_JEV, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0102);
    run(5'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0101);
    flash = 1'b1;
    run(OP_DIV, 8'h11, 8'h04, 8'h80, 8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 16'h0101);
    @(posedge ref_clk);
    ev_raise <= 1'b1;
    run(OP_JEV, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0112);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end
endmodule : tb_cpu_arith_section
`default_nettype wire
